// >>> inc/core_state_pkg.sv
// Constants and types for the processor state core
package core_state_pkg;
  localparam int PC_W = 12;
  localparam int PAGE_W = 10;
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT_IRQ = 12'h003;
  localparam logic [11:0] VEC_TIMER_IRQ = 12'h007;
  localparam int RAM_DEPTH = 256;
  localparam int RAM_AW = 8;
  localparam logic [7:0] BANK0_BASE = 8'h00;
  localparam logic [7:0] BANK1_BASE = 8'h18;
  localparam logic [7:0] STACK_BASE = 8'h08;
  localparam logic [7:0] DIRECT_LIMIT = 8'h20;
  localparam int SP_LO = 0;
  localparam int SP_HI = 2;
  localparam int PSW_ONE_BIT = 3;
  localparam int PSW_BANK_BIT = 4;
  localparam int PSW_F0_BIT = 5;
  localparam int PSW_HC_BIT = 6;
  localparam int PSW_CY_BIT = 7;
  localparam logic [7:0] PSW_RESET = 8'h08;
  localparam logic [7:0] PSW_FIXED_ONE = 8'h08;
  localparam logic [2:0] SP_STEP = 3'h1;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [1:0] INT_BANK = 2'h0;
  localparam logic [1:0] PAGE3 = 2'h3;
  // Register port map
  localparam logic [3:0] ADDR_PSW = 4'h0;
  localparam logic [3:0] ADDR_PC_LO = 4'h1;
  localparam logic [3:0] ADDR_PC_HI = 4'h2;
  typedef enum logic [3:0] {
    OP_NONE, OP_STEP, OP_JUMP, OP_CALL, OP_EXT_IRQ, OP_TIMER_IRQ, OP_RET, OP_RETURN_WITH_STATUS_RESTORE,
    OP_SEL0, OP_SEL1, OP_TABLE_CUR, OP_TABLE_P3, OP_SET_MBANK
  } op_t;
endpackage

// >>> design/data_ram.sv
// Data memory array with one write and two combinational read ports
`timescale 1ns/1ns
module data_ram
  import core_state_pkg::*;
(
  input wire logic core_clk,
  input wire logic we,
  input wire logic [core_state_pkg::RAM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [core_state_pkg::RAM_AW-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [core_state_pkg::RAM_AW-1:0] raddr_b,
  output logic [7:0] rdata_b
);
  // Contents are not reset; software must not rely on power-up values
  logic [7:0] mem [RAM_DEPTH];
  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule

// >>> design/cpu_pc_stack_psw_core.sv
// Program counter, return stack, status word and data memory map
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] Vectors 0 reset, 3 external, 7 timer
// [RULE2] Table read indexes program memory by accumulator
// [RULE3] Bank0 at 0-7, bank1 at 24-31
// [RULE4] One bank active, changed by select or restoring return
// [RULE5] Stack lives at 8-23, two bytes each
// [RULE6] Indirect via work regs reaches all memory
// [RULE7] 12-bit counter, 10-bit page offset
// [RULE8] Upper bits zero internal, else external bank
// [RULE9] Call or interrupt pushes pc plus upper status
// [RULE10] Pointer marks next empty, zero when empty
// [RULE11] Restoring return pops status, plain does not
// [RULE12] Status: pointer, one, bank, user flag
// [RULE13] Bit 6 half carry from adds
// [RULE14] Bit 7 carry from arithmetic and rotate
// [RULE15] Reset clears pc, pointer, banks
// [RULE16] Pointer wraps modulo eight silently
// [RULE17] Bit 3 always reads one
module cpu_pc_stack_psw_core
  import core_state_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire core_state_pkg::op_t op,
  input wire logic [11:0] jump_target,
  input wire logic mbank_sel,
  input wire logic [7:0] acc,
  input wire logic alu_flag_we,
  input wire logic carry_in,
  input wire logic half_carry_in,
  input wire logic carry_only_we,
  input wire logic [2:0] reg_sel,
  input wire logic reg_indirect,
  input wire logic data_we,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic [11:0] fetch_addr,
  output logic fetch_external,
  output logic [7:0] table_result,
  input wire logic [7:0] prog_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata
);
  logic [11:0] instruction_pointer_ff, nxt_instruction_pointer;
  logic [7:0] processor_status_byte_ff, nxt_processor_status_byte;
  logic mbank_ff, nxt_mbank;
  logic [11:0] fetch_addr_ff, nxt_fetch_addr;
  logic fetch_external_ff, nxt_fetch_external;
  logic [7:0] table_result_ff, nxt_table_result;
  logic [7:0] data_rdata_ff, nxt_data_rdata;
  logic [7:0] reg_rdata_ff, nxt_reg_rdata;
  logic ram_we;
  logic [7:0] ram_waddr, ram_wdata, ram_raddr_a, ram_raddr_b, ram_rdata_a, ram_rdata_b;
  logic [7:0] stack_lo, stack_hi;
  logic [2:0] sp, sp_pop;
  logic [7:0] work_addr;
  logic push_hi_pending_ff, nxt_push_hi_pending;
  logic [7:0] push_hi_byte_ff, nxt_push_hi_byte;
  logic [7:0] push_hi_addr_ff, nxt_push_hi_addr;
  logic table_wait_ff, nxt_table_wait;

  // Byte address of a stack slot, low byte first
  function automatic logic [7:0] slot_addr(input logic [2:0] slot, input logic hi);
    slot_addr = STACK_BASE + {4'h0, slot, hi};
  endfunction

  // Working register address inside the active bank
  function automatic logic [7:0] bank_addr(input logic bank, input logic [2:0] r);
    bank_addr = (bank ? BANK1_BASE : BANK0_BASE) + {5'h00, r};
  endfunction

  assign sp = processor_status_byte_ff[SP_HI:SP_LO];
  assign sp_pop = sp - SP_STEP; // [RULE16]
  assign stack_lo = ram_rdata_a;
  // A pop right behind a push must see the high byte still on its way to memory
  assign stack_hi = (push_hi_pending_ff && push_hi_addr_ff == ram_raddr_b) ? push_hi_byte_ff : ram_rdata_b;

  data_ram u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr_a(ram_raddr_a),
    .rdata_a(ram_rdata_a),
    .raddr_b(ram_raddr_b),
    .rdata_b(ram_rdata_b)
  );

  // Port b fetches work reg 0/1 pointer for indirect access, or stack high byte on pops
  always_comb
  begin
    work_addr = bank_addr(processor_status_byte_ff[PSW_BANK_BIT], reg_sel); // [RULE3] [RULE4]
    ram_raddr_a = slot_addr(sp_pop, 1'b0);
    ram_raddr_b = slot_addr(sp_pop, 1'b1);
    if (op != OP_RET && op != OP_RETURN_WITH_STATUS_RESTORE)
    begin
      ram_raddr_b = bank_addr(processor_status_byte_ff[PSW_BANK_BIT], {2'b00, reg_sel[0]});
      // Indirect reaches every location through work_reg_zero or work_reg_one
      ram_raddr_a = reg_indirect ? ram_rdata_b : work_addr; // [RULE6]
    end
  end

  // Push writes two bytes unless it directly follows another push; the port has one write lane, so the high byte lands a cycle later
  always_comb
  begin
    ram_we = 1'b0;
    ram_waddr = ram_raddr_a;
    ram_wdata = data_wdata;
    nxt_push_hi_pending = 1'b0;
    nxt_push_hi_byte = push_hi_byte_ff;
    nxt_push_hi_addr = push_hi_addr_ff;
    if (push_hi_pending_ff)
    begin
      ram_we = 1'b1;
      ram_waddr = push_hi_addr_ff;
      ram_wdata = push_hi_byte_ff;
    end
    else if (op == OP_CALL || op == OP_EXT_IRQ || op == OP_TIMER_IRQ)
    begin
      ram_we = 1'b1; // [RULE9] [RULE5]
      ram_waddr = slot_addr(sp, 1'b0);
      ram_wdata = instruction_pointer_ff[7:0];
      nxt_push_hi_pending = 1'b1;
      nxt_push_hi_addr = slot_addr(sp, 1'b1);
      nxt_push_hi_byte = {processor_status_byte_ff[7:4], instruction_pointer_ff[11:8]};
    end
    else if (data_we && op != OP_RET && op != OP_RETURN_WITH_STATUS_RESTORE)
    begin
      ram_we = 1'b1;
    end
  end

  always_comb
  begin
    nxt_instruction_pointer = instruction_pointer_ff;
    nxt_processor_status_byte = processor_status_byte_ff;
    nxt_mbank = mbank_ff;
    nxt_table_result = table_result_ff;
    nxt_table_wait = 1'b0;
    case (op)
      OP_STEP: nxt_instruction_pointer = instruction_pointer_ff + PC_STEP; // [RULE7]
      OP_JUMP: nxt_instruction_pointer = {mbank_ff, jump_target[10:0]};
      OP_CALL:
      begin
        nxt_instruction_pointer = {mbank_ff, jump_target[10:0]};
        nxt_processor_status_byte[SP_HI:SP_LO] = sp + SP_STEP; // [RULE10] [RULE16]
      end
      OP_EXT_IRQ:
      begin
        nxt_instruction_pointer = VEC_EXT_IRQ; // [RULE1]
        nxt_processor_status_byte[SP_HI:SP_LO] = sp + SP_STEP;
      end
      OP_TIMER_IRQ:
      begin
        nxt_instruction_pointer = VEC_TIMER_IRQ; // [RULE1]
        nxt_processor_status_byte[SP_HI:SP_LO] = sp + SP_STEP;
      end
      OP_RET:
      begin
        nxt_instruction_pointer = {stack_hi[3:0], stack_lo}; // [RULE11]
        nxt_processor_status_byte[SP_HI:SP_LO] = sp_pop;
      end
      OP_RETURN_WITH_STATUS_RESTORE:
      begin
        nxt_instruction_pointer = {stack_hi[3:0], stack_lo};
        nxt_processor_status_byte[7:4] = stack_hi[7:4]; // [RULE11]
        nxt_processor_status_byte[SP_HI:SP_LO] = sp_pop;
      end
      OP_SEL0: nxt_processor_status_byte[PSW_BANK_BIT] = 1'b0; // [RULE4]
      OP_SEL1: nxt_processor_status_byte[PSW_BANK_BIT] = 1'b1; // [RULE4]
      OP_TABLE_CUR: nxt_table_wait = 1'b1; // [RULE2]
      OP_TABLE_P3: nxt_table_wait = 1'b1; // [RULE2]
      OP_SET_MBANK: nxt_mbank = mbank_sel;
      default: nxt_instruction_pointer = instruction_pointer_ff;
    endcase
    // Table byte arrives a cycle after the table address goes out
    if (table_wait_ff)
    begin
      nxt_table_result = prog_rdata; // [RULE2]
    end
    if (alu_flag_we)
    begin
      nxt_processor_status_byte[PSW_HC_BIT] = half_carry_in; // [RULE13]
      nxt_processor_status_byte[PSW_CY_BIT] = carry_in; // [RULE14]
    end
    else if (carry_only_we)
    begin
      nxt_processor_status_byte[PSW_CY_BIT] = carry_in; // [RULE14]
    end
    // Software write of the status word; bank bit excluded so only select ops and restoring return move it
    if (reg_we && reg_addr == ADDR_PSW)
    begin
      nxt_processor_status_byte = {reg_wdata[7:5], processor_status_byte_ff[PSW_BANK_BIT], reg_wdata[3:0]}; // [RULE17]
    end
    nxt_processor_status_byte = nxt_processor_status_byte | PSW_FIXED_ONE; // [RULE12] [RULE17]
  end

  // Fetch address: page-3 table read or current page with accumulator index
  always_comb
  begin
    nxt_fetch_addr = nxt_instruction_pointer;
    if (op == OP_TABLE_CUR)
    begin
      nxt_fetch_addr = {instruction_pointer_ff[11:8], acc};
    end
    else if (op == OP_TABLE_P3)
    begin
      nxt_fetch_addr = {instruction_pointer_ff[11:PAGE_W], PAGE3, acc};
    end
    nxt_fetch_external = nxt_fetch_addr[11:PAGE_W] != INT_BANK; // [RULE8]
    nxt_data_rdata = ram_rdata_a;
    nxt_reg_rdata = reg_rdata_ff;
    if (reg_re)
    begin
      case (reg_addr)
        ADDR_PSW: nxt_reg_rdata = processor_status_byte_ff;
        ADDR_PC_LO: nxt_reg_rdata = instruction_pointer_ff[7:0];
        ADDR_PC_HI: nxt_reg_rdata = {3'h0, mbank_ff, instruction_pointer_ff[11:8]};
        default: nxt_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      instruction_pointer_ff <= VEC_RESET; // [RULE1] [RULE15]
      processor_status_byte_ff <= PSW_RESET; // [RULE15]
      mbank_ff <= 1'b0;
      fetch_addr_ff <= VEC_RESET;
      fetch_external_ff <= 1'b0;
      table_result_ff <= 8'h00;
      data_rdata_ff <= 8'h00;
      reg_rdata_ff <= 8'h00;
      push_hi_pending_ff <= 1'b0;
      push_hi_byte_ff <= 8'h00;
      push_hi_addr_ff <= 8'h00;
      table_wait_ff <= 1'b0;
    end
    else
    begin
      instruction_pointer_ff <= nxt_instruction_pointer;
      processor_status_byte_ff <= nxt_processor_status_byte;
      mbank_ff <= nxt_mbank;
      fetch_addr_ff <= nxt_fetch_addr;
      fetch_external_ff <= nxt_fetch_external;
      table_result_ff <= nxt_table_result;
      data_rdata_ff <= nxt_data_rdata;
      reg_rdata_ff <= nxt_reg_rdata;
      push_hi_pending_ff <= nxt_push_hi_pending;
      push_hi_byte_ff <= nxt_push_hi_byte;
      push_hi_addr_ff <= nxt_push_hi_addr;
      table_wait_ff <= nxt_table_wait;
    end
  end

  assign fetch_addr = fetch_addr_ff;
  assign fetch_external = fetch_external_ff;
  assign table_result = table_result_ff;
  assign data_rdata = data_rdata_ff;
  assign reg_rdata = reg_rdata_ff;

  a_one_bit_fixed: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
    processor_status_byte_ff[PSW_ONE_BIT]) else $error("status bit 3 not one");
  a_ext_vector: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    op == OP_EXT_IRQ |=> instruction_pointer_ff == VEC_EXT_IRQ) else $error("bad external vector");
  a_timer_vector: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    op == OP_TIMER_IRQ |=> instruction_pointer_ff == VEC_TIMER_IRQ) else $error("bad timer vector");
  a_push_ptr_up: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
    op == OP_CALL && !(reg_we && reg_addr == ADDR_PSW) |=> sp == $past(sp) + SP_STEP)
    else $error("push pointer wrong");
  a_pop_ptr_down: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
    (op == OP_RET || op == OP_RETURN_WITH_STATUS_RESTORE) && !(reg_we && reg_addr == ADDR_PSW) |=> sp == $past(sp) - SP_STEP)
    else $error("pop pointer wrong");
  a_ret_keeps_flags: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
    op == OP_RET && !alu_flag_we && !carry_only_we && !reg_we |=>
    processor_status_byte_ff[7:4] == $past(processor_status_byte_ff[7:4])) else $error("ret changed status");
  a_return_with_status_restore_restores: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
    op == OP_RETURN_WITH_STATUS_RESTORE && !alu_flag_we && !carry_only_we && !reg_we |=>
    processor_status_byte_ff[7:4] == $past(stack_hi[7:4])) else $error("status not restored");
  a_reset_clears: assert property (@(posedge core_clk) // [RULE15]
    rst |=> instruction_pointer_ff == VEC_RESET && sp == 3'h0 && !mbank_ff) else $error("reset state wrong");
  a_bank_hold: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
    op != OP_SEL0 && op != OP_SEL1 && op != OP_RETURN_WITH_STATUS_RESTORE |=>
    processor_status_byte_ff[PSW_BANK_BIT] == $past(processor_status_byte_ff[PSW_BANK_BIT]))
    else $error("bank moved");
  a_external_fetch: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
    fetch_external == (fetch_addr[11:PAGE_W] != INT_BANK)) else $error("fetch bank flag wrong");
  a_push_high: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
    op == OP_CALL && !push_hi_pending_ff |=> ram_we && ram_waddr == slot_addr($past(sp), 1'b1))
    else $error("high byte not pushed");
  a_table_index: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
    op == OP_TABLE_CUR || op == OP_TABLE_P3 |=> fetch_addr[7:0] == $past(acc)) else $error("table index wrong");
  a_table_capture: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
    table_wait_ff |=> table_result == $past(prog_rdata)) else $error("table byte not captured");
  c_call: cover property (@(posedge core_clk) op == OP_CALL ##1 op == OP_RET);
  c_table: cover property (@(posedge core_clk) table_wait_ff);
  c_irq_return_with_status_restore: cover property (@(posedge core_clk) op == OP_EXT_IRQ ##2 op == OP_RETURN_WITH_STATUS_RESTORE);
  c_wrap: cover property (@(posedge core_clk) op == OP_CALL && sp == 3'h7);
endmodule

// >>> sim/cpu_pc_stack_psw_core_tb_top.sv
// Self-checking testbench for the processor state core
`timescale 1ns/1ns
module cpu_pc_stack_psw_core_tb_top;
  import core_state_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  op_t op = OP_NONE;
  logic [11:0] jump_target = 12'h000;
  logic mbank_sel = 1'b0;
  logic [7:0] acc = 8'h00;
  logic alu_flag_we = 1'b0;
  logic carry_in = 1'b0;
  logic half_carry_in = 1'b0;
  logic carry_only_we = 1'b0;
  logic [2:0] reg_sel = 3'h0;
  logic reg_indirect = 1'b0;
  logic data_we = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] data_rdata;
  logic [11:0] fetch_addr;
  logic fetch_external;
  logic [7:0] table_result;
  logic [7:0] prog_rdata = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  int mismatches = 0;
  int check_count = 0;
  always #20 core_clk = ~core_clk;
  cpu_pc_stack_psw_core u_cpu_pc_stack_psw_core (.core_clk(core_clk), .rst(rst), .op(op),
    .jump_target(jump_target), .mbank_sel(mbank_sel), .acc(acc), .alu_flag_we(alu_flag_we),
    .carry_in(carry_in), .half_carry_in(half_carry_in), .carry_only_we(carry_only_we),
    .reg_sel(reg_sel), .reg_indirect(reg_indirect), .data_we(data_we), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .fetch_addr(fetch_addr), .fetch_external(fetch_external),
    .table_result(table_result), .prog_rdata(prog_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Op held for exactly one edge; results settle before the #1 sample
  task automatic run_op(input op_t o);
    @(posedge core_clk);
    op <= o;
    @(posedge core_clk);
    op <= OP_NONE;
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask
  task automatic wr_data(input logic [2:0] s, input logic [7:0] d);
    @(posedge core_clk);
    reg_sel <= s;
    data_we <= 1'b1;
    data_wdata <= d;
    @(posedge core_clk);
    data_we <= 1'b0;
  endtask
  // Return lands on the address that was current when the push was taken
  task automatic chk_ret(input logic [11:0] p);
    chk(fetch_addr, p);
  endtask
  // Call and return on adjacent edges, while the pushed high byte is still in flight
  task automatic call_ret_chk(input logic [11:0] p);
    @(posedge core_clk);
    op <= OP_CALL;
    @(posedge core_clk);
    op <= OP_RET;
    @(posedge core_clk);
    op <= OP_NONE;
    #1;
    chk(fetch_addr, p);
  endtask
  task automatic t_reset();
    chk(fetch_addr, VEC_RESET);
    rd_chk(ADDR_PSW, PSW_RESET);
    rd_chk(ADDR_PC_HI, 8'h00);
    rd_chk(4'hF, 8'h00);
  endtask
  task automatic t_psw_write();
    wr_reg(ADDR_PSW, 8'hF5);
    rd_chk(ADDR_PSW, 8'hED);
    wr_reg(ADDR_PSW, 8'h10);
    rd_chk(ADDR_PSW, 8'h08);
  endtask
  task automatic t_flags();
    @(posedge core_clk);
    alu_flag_we <= 1'b1;
    carry_in <= 1'b1;
    half_carry_in <= 1'b1;
    @(posedge core_clk);
    alu_flag_we <= 1'b0;
    carry_only_we <= 1'b1;
    carry_in <= 1'b0;
    @(posedge core_clk);
    carry_only_we <= 1'b0;
    rd_chk(ADDR_PSW, 8'h48);
    wr_reg(ADDR_PSW, 8'h00);
  endtask
  task automatic t_vectors();
    run_op(OP_EXT_IRQ);
    chk(fetch_addr, VEC_EXT_IRQ);
    rd_chk(ADDR_PSW, 8'h09);
    run_op(OP_TIMER_IRQ);
    chk(fetch_addr, VEC_TIMER_IRQ);
    run_op(OP_RETURN_WITH_STATUS_RESTORE);
    chk_ret(VEC_EXT_IRQ);
    run_op(OP_RETURN_WITH_STATUS_RESTORE);
    rd_chk(ADDR_PSW, 8'h08);
  endtask
  task automatic t_bank_restore();
    jump_target <= 12'h040;
    run_op(OP_CALL);
    chk(fetch_addr, 12'h040);
    run_op(OP_SEL1);
    rd_chk(ADDR_PSW, 8'h19);
    run_op(OP_RETURN_WITH_STATUS_RESTORE);
    rd_chk(ADDR_PSW, 8'h08);
    run_op(OP_JUMP);
    run_op(OP_CALL);
    run_op(OP_SEL1);
    run_op(OP_RET);
    chk_ret(12'h040);
    rd_chk(ADDR_PSW, 8'h18);
    run_op(OP_SEL0);
  endtask
  task automatic t_wrap();
    repeat (8) run_op(OP_CALL);
    rd_chk(ADDR_PSW, 8'h08);
    run_op(OP_RET);
    rd_chk(ADDR_PSW, 8'h0F);
  endtask
  task automatic t_ram();
    run_op(OP_SEL1);
    wr_data(3'h0, 8'h5A);
    run_op(OP_SEL0);
    wr_data(3'h0, BANK1_BASE);
    @(posedge core_clk);
    reg_indirect <= 1'b1;
    #1;
    chk({4'h0, data_rdata}, {4'h0, BANK1_BASE});
    @(posedge core_clk);
    reg_indirect <= 1'b0;
    #1;
    chk({4'h0, data_rdata}, 12'h05A);
  endtask
  task automatic t_mbank_table();
    mbank_sel <= 1'b1;
    jump_target <= 12'h123;
    run_op(OP_SET_MBANK);
    run_op(OP_JUMP);
    chk(fetch_addr, 12'h923);
    chk({11'h0, fetch_external}, 12'h001);
    rd_chk(ADDR_PC_LO, 8'h23);
    call_ret_chk(12'h923);
    rd_chk(ADDR_PC_HI, 8'h19);
    mbank_sel <= 1'b0;
    run_op(OP_SET_MBANK);
    run_op(OP_JUMP);
    run_op(OP_STEP);
    chk(fetch_addr, 12'h124);
    chk({11'h0, fetch_external}, 12'h000);
    acc <= 8'h37;
    prog_rdata <= 8'h00;
    run_op(OP_TABLE_CUR);
    chk(fetch_addr, 12'h137);
    prog_rdata <= 8'hA5;
    @(posedge core_clk);
    #1;
    chk({4'h0, table_result}, 12'h0A5);
    prog_rdata <= 8'h00;
    run_op(OP_TABLE_P3);
    chk(fetch_addr, 12'h337);
    prog_rdata <= 8'h3C;
    @(posedge core_clk);
    #1;
    chk({4'h0, table_result}, 12'h03C);
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_psw_write();
    t_flags();
    t_vectors();
    t_bank_restore();
    t_wrap();
    t_ram();
    t_mbank_table();
    // Mid-run reset must clear the pointer, counter and memory bank left nonzero here
    mbank_sel <= 1'b1;
    run_op(OP_SET_MBANK);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    t_reset();
    report_and_stop();
  end
  initial
  begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule
